//--- common/iccr_pkg.sv
`default_nettype none
package iccr_pkg;
    localparam logic [4:0] IDX_CHIP_ID = 5'h00;
    localparam logic [4:0] IDX_SYS_CLOCK = 5'h01;
    localparam logic [4:0] IDX_SYS_PARAM = 5'h02;
    localparam logic [4:0] IDX_COPROC = 5'h04;
    localparam logic [4:0] IDX_DMA = 5'h06;
    localparam logic [4:0] IDX_ROM = 5'h07;
    localparam logic [4:0] IDX_HOLE_EN = 5'h08;
    localparam logic [4:0] IDX_IOA_LO = 5'h10;
    localparam logic [4:0] IDX_IOA_HI = 5'h11;
    localparam logic [4:0] IDX_IOB_LO = 5'h12;
    localparam logic [4:0] IDX_IOB_HI = 5'h13;
    localparam logic [4:0] IDX_MEMA_LO = 5'h16;
    localparam logic [4:0] IDX_MEMA_UP = 5'h17;
    localparam logic [4:0] IDX_MEMB_SLO = 5'h19;
    localparam logic [4:0] IDX_MEMB_SUP = 5'h1a;
    localparam logic [4:0] IDX_MEMB_ELO = 5'h1c;
    localparam logic [4:0] IDX_MEMB_EUP = 5'h1d;
    localparam int NUM_INDEX = 32;
    localparam logic [15:0] PORT_DATA = 16'h0024;
    localparam logic [15:0] PORT_INDEX = 16'h0028;
    localparam logic [15:0] PORT_FPU_RESET = 16'h00f1;
    localparam logic [15:0] EXT_PAGE_LO = 16'h0480;
    localparam logic [15:0] EXT_PAGE_HI = 16'h048f;
    localparam logic [3:0] CHIP_REVISION = 4'h1;
    localparam logic [3:0] CHIP_IDENT = 4'h5;
    localparam logic [7:0] RESET_VALUE = 8'h00;
    localparam logic [4:0] RESET_INDEX = 5'h00;
    localparam int BIT_POST = 0;
    localparam int BIT_IO16 = 1;
    localparam int BIT_ALT_PORT = 2;
    localparam int BIT_CYC_LO = 3;
    localparam int BIT_PAR_OVR = 5;
    localparam int BIT_FPU_STD = 0;
    localparam int BIT_FPU_ALT = 1;
    localparam int BIT_FPU_BLOCK = 2;
    localparam int BIT_DMA_CLK = 0;
    localparam int BIT_EXT_PAGE = 1;
    localparam int BIT_DRAIN = 2;
    localparam int BIT_DMA_WAIT_LO = 3;
    localparam int BIT_ROM_OE = 0;
    localparam int BIT_VIDEO_BIOS = 1;
    localparam int BIT_ROM_128K = 2;
    localparam int BIT_MID_BIOS = 3;
    localparam int BIT_MEMA_EN = 0;
    localparam int BIT_MEMB_EN = 1;
    localparam int BIT_IOA_EN = 3;
    localparam int BIT_IOB_EN = 4;
    localparam logic [7:0] MASK_SYS_CLOCK = 8'h0f;
    localparam logic [7:0] MASK_SYS_PARAM = 8'h3f;
    localparam logic [7:0] MASK_COPROC = 8'h07;
    localparam logic [7:0] MASK_DMA = 8'h1f;
    localparam logic [7:0] MASK_ROM = 8'h0f;
    localparam logic [7:0] MASK_HOLE_EN = 8'h1b;
    localparam logic [7:0] MASK_MEM_UP = 8'h3f;
    localparam logic [2:0] CYCLES_BASE = 3'h6;
    localparam logic [1:0] DMA_WAIT_BASE = 2'h3;
    localparam int CLK_MHZ = 20;
    localparam int ROM_OE_LONG_NS = 250;
    localparam int ROM_OE_SHORT_NS = 125;
    localparam logic [3:0] ROM_OE_LONG_CYC = 4'((ROM_OE_LONG_NS * CLK_MHZ + 999) / 1000);
    localparam logic [3:0] ROM_OE_SHORT_CYC = 4'((ROM_OE_SHORT_NS * CLK_MHZ + 999) / 1000);

    typedef struct packed {
        logic post_en;
        logic io_decode_16;
        logic alt_port_en;
        logic [2:0] backplane_cycles;
        logic parity_override;
        logic fpu_std_present;
        logic fpu_alt_present;
        logic dma_clk_inverted;
        logic ext_page_en;
        logic drain_handshake;
        logic [1:0] dma_wait_select;
        logic [3:0] rom_oe_cycles;
        logic video_bios_shared;
        logic rom_128k;
        logic mid_bios_en;
        logic rom_8bit;
        logic [3:0] clock_select;
    } iccr_config_type;
endpackage : iccr_pkg
`default_nettype wire

//--- core/iccr_regs.sv
// Behaviour
// - Thirty-two indexed locations 00h-1Fh, reached through the data port.
// - Pointer held here; every access to port 28h is claimed; reads return it.
// - Write index to 28h, then read or write the selected register at 24h.
// - Pointer holds until next write to 28h; resets to chip_revision_id.
// - Chip_revision_id read-only: revision in bits 3:0, identifier in bits 7:4.
// - System_clock_select bits 3:0 select system clock; reserved codes not programmed.
// - Posting bit lets backplane memory writes end early through local ready.
// - Bit 1 of system_parameters chooses 10-bit or 16-bit I/O decode.
// - Bit 2 of system_parameters enables alternate system control port functions.
// - System_parameters bits 4:3 give backplane cycle of 6,5,4 or 3 clocks.
// - Bit 5 of system_parameters blocks parity errors from the NMI logic.
// - Coprocessor_config bits 0 and 1 report coprocessors installed; bits 7:3 zero.
// - Write to port 0F1h pulses coprocessor reset unless coprocessor_config bit 2 set.
// - Dma_config bit 0: DMA clock is backplane clock halved or inverted.
// - Dma_config bit 1 enables extended DMA page registers at 480h-48Fh.
// - With drain handshake, hold grant to DMA waits for memory ready.
// - Rom_config bit 0 selects ROM output enable width 250 ns or 125 ns.
// - Rom_config bits 1-3 set video BIOS sharing, 128K size, middle BIOS.
// - A20 clamp pin sampled at reset sets ROM width: high 8-bit, low 16-bit.
// - Cycles inside an enabled hole are neither started nor terminated here, except accesses to ports 24h and 28h.
// - I/O holes have 16-byte granularity; high register holds top plus one.
// - Memory hole A is a fixed 16K window; hole B spans start to end.
// - Hole_enable: bit0 memory A, bit1 memory B, bit3 I/O A, bit4 I/O B; others zero.
`default_nettype none
module iccr_regs (
    input wire logic CLK_SYS,
    input wire logic RST_B,
    input wire logic IO_WRITE,
    input wire logic IO_READ,
    input wire logic [15:0] IO_ADDR,
    input wire logic [7:0] IO_WDATA,
    output logic [7:0] IO_RDATA,
    output logic IO_CLAIM,
    input wire logic [27:0] MEM_ADDR,
    input wire logic MEM_CYCLE,
    input wire logic BACKPLANE_MEM_WRITE,
    output logic LOCAL_READY_N,
    output logic IO_HOLE_HIT,
    output logic MEM_HOLE_HIT,
    output logic FPU_RESET_OUT,
    output logic EXT_PAGE_SELECT,
    output logic ALT_PORT_SELECT,
    input wire logic PARITY_N,
    output logic PARITY_ERROR_TO_NMI,
    input wire logic HOLD_ACK_CPU,
    input wire logic MEM_READY_N,
    output logic DMA_HOLD_ACK,
    input wire logic ADDR20_CLAMP_N,
    output iccr_pkg::iccr_config_type CONFIG
);
    logic [7:0] regs [iccr_pkg::NUM_INDEX];
    logic [4:0] index_ptr;
    logic strap_taken;
    logic rom_8bit;
    logic [2:0] parity_sync;
    logic [2:0] ready_sync;
    logic [2:0] strap_sync;
    logic parity_seen;
    logic ready_seen;
    logic [7:0] sys_param;
    logic [7:0] coproc;
    logic [7:0] dma_cfg;
    logic [7:0] rom_cfg;
    logic [7:0] hole_en;

    function automatic logic port_hit(input logic [15:0] addr, input logic [15:0] port, input logic full);
        if (full) begin
            port_hit = addr == port;
        end else begin
            port_hit = addr[9:0] == port[9:0];
        end
    endfunction : port_hit

    function automatic logic in_range(input logic [13:0] addr, input logic [13:0] lo, input logic [13:0] hi);
        in_range = addr >= lo && addr < hi;
    endfunction : in_range

    function automatic logic [7:0] write_mask(input logic [4:0] idx);
        case (idx)
            iccr_pkg::IDX_CHIP_ID: write_mask = 8'h00;
            iccr_pkg::IDX_SYS_CLOCK: write_mask = iccr_pkg::MASK_SYS_CLOCK;
            iccr_pkg::IDX_SYS_PARAM: write_mask = iccr_pkg::MASK_SYS_PARAM;
            iccr_pkg::IDX_COPROC: write_mask = iccr_pkg::MASK_COPROC;
            iccr_pkg::IDX_DMA: write_mask = iccr_pkg::MASK_DMA;
            iccr_pkg::IDX_ROM: write_mask = iccr_pkg::MASK_ROM;
            iccr_pkg::IDX_HOLE_EN: write_mask = iccr_pkg::MASK_HOLE_EN;
            iccr_pkg::IDX_MEMA_UP,
            iccr_pkg::IDX_MEMB_SUP,
            iccr_pkg::IDX_MEMB_EUP: write_mask = iccr_pkg::MASK_MEM_UP;
            default: write_mask = 8'hff;
        endcase
    endfunction : write_mask

    logic io16;
    logic index_sel;
    logic data_sel;
    logic fpu_sel;

    assign sys_param = regs[iccr_pkg::IDX_SYS_PARAM];
    assign coproc = regs[iccr_pkg::IDX_COPROC];
    assign dma_cfg = regs[iccr_pkg::IDX_DMA];
    assign rom_cfg = regs[iccr_pkg::IDX_ROM];
    assign hole_en = regs[iccr_pkg::IDX_HOLE_EN];
    assign io16 = sys_param[iccr_pkg::BIT_IO16];

    // The configuration ports stay claimed inside a hole too, so software can always undo a bad hole.
    assign index_sel = port_hit(IO_ADDR, iccr_pkg::PORT_INDEX, io16);
    assign data_sel = port_hit(IO_ADDR, iccr_pkg::PORT_DATA, io16);
    assign fpu_sel = port_hit(IO_ADDR, iccr_pkg::PORT_FPU_RESET, io16) && !IO_HOLE_HIT;

    // Pointer survives data accesses so repeated reads hit the same register.
    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            index_ptr <= iccr_pkg::RESET_INDEX;
        end else if (IO_WRITE && index_sel) begin
            index_ptr <= IO_WDATA[4:0];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < iccr_pkg::NUM_INDEX; gi++) begin : g_reg
            always_ff @(posedge CLK_SYS) begin
                if (!RST_B) begin
                    regs[gi] <= iccr_pkg::RESET_VALUE;
                end else if (gi == 0) begin
                    regs[gi] <= {iccr_pkg::CHIP_IDENT, iccr_pkg::CHIP_REVISION};
                end else if (IO_WRITE && data_sel && index_ptr == 5'(gi)) begin
                    regs[gi] <= IO_WDATA & write_mask(5'(gi));
                end
            end
        end
    endgenerate

    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            IO_RDATA <= 8'h00;
        end else if (IO_READ && index_sel) begin
            IO_RDATA <= {3'h0, index_ptr};
        end else if (IO_READ && data_sel) begin
            IO_RDATA <= regs[index_ptr];
        end
    end

    assign IO_CLAIM = (IO_READ || IO_WRITE) && (index_sel || data_sel);

    // The strap chain runs through reset, so it has settled by the time reset is released.
    always_ff @(posedge CLK_SYS) begin
        strap_sync <= {strap_sync[1:0], ADDR20_CLAMP_N};
    end

    // The strap is caught on the first settled edge after reset release.
    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            strap_taken <= 1'b0;
            rom_8bit <= 1'b0;
        end else if (!strap_taken && strap_sync[2] == strap_sync[1]) begin
            strap_taken <= 1'b1;
            rom_8bit <= strap_sync[2];
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            parity_sync <= 3'h0;
            parity_seen <= 1'b0;
        end else begin
            parity_sync <= {parity_sync[1:0], !PARITY_N};
            if (parity_sync[2] == parity_sync[1]) begin
                parity_seen <= parity_sync[2];
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            ready_sync <= 3'h0;
            ready_seen <= 1'b0;
        end else begin
            ready_sync <= {ready_sync[1:0], !MEM_READY_N};
            if (ready_sync[2] == ready_sync[1]) begin
                ready_seen <= ready_sync[2];
            end
        end
    end

    assign PARITY_ERROR_TO_NMI = parity_seen && !sys_param[iccr_pkg::BIT_PAR_OVR];

    // Once granted, the DMA side keeps its grant until the CPU drops hold.
    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            DMA_HOLD_ACK <= 1'b0;
        end else if (!HOLD_ACK_CPU) begin
            DMA_HOLD_ACK <= 1'b0;
        end else if (!dma_cfg[iccr_pkg::BIT_DRAIN] || ready_seen) begin
            DMA_HOLD_ACK <= 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            FPU_RESET_OUT <= 1'b0;
        end else begin
            FPU_RESET_OUT <= IO_WRITE && fpu_sel && !coproc[iccr_pkg::BIT_FPU_BLOCK];
        end
    end

    logic [11:4] io_a_lo;
    logic [11:4] io_a_hi;
    logic [11:4] io_b_lo;
    logic [11:4] io_b_hi;
    logic [27:14] mem_a;
    logic [27:14] mem_b_start;
    logic [27:14] mem_b_end;
    logic io_a_hit;
    logic io_b_hit;

    assign io_a_lo = regs[iccr_pkg::IDX_IOA_LO];
    assign io_a_hi = regs[iccr_pkg::IDX_IOA_HI];
    assign io_b_lo = regs[iccr_pkg::IDX_IOB_LO];
    assign io_b_hi = regs[iccr_pkg::IDX_IOB_HI];
    assign mem_a = {regs[iccr_pkg::IDX_MEMA_UP][5:0], regs[iccr_pkg::IDX_MEMA_LO]};
    assign mem_b_start = {regs[iccr_pkg::IDX_MEMB_SUP][5:0], regs[iccr_pkg::IDX_MEMB_SLO]};
    assign mem_b_end = {regs[iccr_pkg::IDX_MEMB_EUP][5:0], regs[iccr_pkg::IDX_MEMB_ELO]};

    // Hole comparators see address bits 11:4 only, so holes repeat every 4K of I/O space.
    assign io_a_hit = hole_en[iccr_pkg::BIT_IOA_EN]
        && in_range({6'h00, IO_ADDR[11:4]}, {6'h00, io_a_lo}, {6'h00, io_a_hi});
    assign io_b_hit = hole_en[iccr_pkg::BIT_IOB_EN]
        && in_range({6'h00, IO_ADDR[11:4]}, {6'h00, io_b_lo}, {6'h00, io_b_hi});
    assign IO_HOLE_HIT = io_a_hit || io_b_hit;

    assign MEM_HOLE_HIT = (hole_en[iccr_pkg::BIT_MEMA_EN] && MEM_ADDR[27:14] == mem_a)
        || (hole_en[iccr_pkg::BIT_MEMB_EN] && in_range(MEM_ADDR[27:14], mem_b_start, mem_b_end));

    // Early ready for posted backplane writes, withheld where another device owns the cycle.
    assign LOCAL_READY_N = !(MEM_CYCLE && BACKPLANE_MEM_WRITE && sys_param[iccr_pkg::BIT_POST]
        && !MEM_HOLE_HIT);

    assign EXT_PAGE_SELECT = dma_cfg[iccr_pkg::BIT_EXT_PAGE] && !IO_HOLE_HIT
        && IO_ADDR >= iccr_pkg::EXT_PAGE_LO && IO_ADDR <= iccr_pkg::EXT_PAGE_HI;
    assign ALT_PORT_SELECT = sys_param[iccr_pkg::BIT_ALT_PORT];

    always_comb begin
        CONFIG.post_en = sys_param[iccr_pkg::BIT_POST];
        CONFIG.io_decode_16 = io16;
        CONFIG.alt_port_en = sys_param[iccr_pkg::BIT_ALT_PORT];
        CONFIG.backplane_cycles = iccr_pkg::CYCLES_BASE
            - {1'b0, sys_param[iccr_pkg::BIT_CYC_LO +: 2]};
        CONFIG.parity_override = sys_param[iccr_pkg::BIT_PAR_OVR];
        CONFIG.fpu_std_present = coproc[iccr_pkg::BIT_FPU_STD];
        CONFIG.fpu_alt_present = coproc[iccr_pkg::BIT_FPU_ALT];
        CONFIG.dma_clk_inverted = dma_cfg[iccr_pkg::BIT_DMA_CLK];
        CONFIG.ext_page_en = dma_cfg[iccr_pkg::BIT_EXT_PAGE];
        CONFIG.drain_handshake = dma_cfg[iccr_pkg::BIT_DRAIN];
        CONFIG.dma_wait_select = iccr_pkg::DMA_WAIT_BASE - dma_cfg[iccr_pkg::BIT_DMA_WAIT_LO +: 2];
        CONFIG.rom_oe_cycles = rom_cfg[iccr_pkg::BIT_ROM_OE]
            ? iccr_pkg::ROM_OE_SHORT_CYC : iccr_pkg::ROM_OE_LONG_CYC;
        CONFIG.video_bios_shared = rom_cfg[iccr_pkg::BIT_VIDEO_BIOS];
        CONFIG.rom_128k = rom_cfg[iccr_pkg::BIT_ROM_128K];
        CONFIG.mid_bios_en = rom_cfg[iccr_pkg::BIT_MID_BIOS];
        CONFIG.rom_8bit = rom_8bit;
        CONFIG.clock_select = regs[iccr_pkg::IDX_SYS_CLOCK][3:0];
    end
endmodule : iccr_regs
`default_nettype wire

//--- dv/iccr_properties.sv
`default_nettype none
module iccr_properties (
    input wire logic CLK_SYS,
    input wire logic RST_B,
    input wire logic IO_WRITE,
    input wire logic IO_READ,
    input wire logic [15:0] IO_ADDR,
    input wire logic [7:0] IO_RDATA,
    input wire logic IO_CLAIM,
    input wire logic MEM_CYCLE,
    input wire logic BACKPLANE_MEM_WRITE,
    input wire logic LOCAL_READY_N,
    input wire logic MEM_HOLE_HIT,
    input wire logic FPU_RESET_OUT,
    input wire logic EXT_PAGE_SELECT,
    input wire logic ALT_PORT_SELECT,
    input wire logic PARITY_ERROR_TO_NMI,
    input wire logic HOLD_ACK_CPU,
    input wire logic DMA_HOLD_ACK,
    input wire iccr_pkg::iccr_config_type CONFIG
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_B);
    sequence s_fpu_write;
        IO_WRITE && IO_ADDR[9:0] == 10'h0f1;
    endsequence
    a_index_claim: assert property (IO_WRITE && IO_ADDR == 16'h0028 |-> IO_CLAIM)
        else $error("index port access not claimed");
    a_data_claim: assert property (IO_READ && IO_ADDR == 16'h0024 |-> IO_CLAIM)
        else $error("data port access not claimed");
    a_pointer_read: assert property (IO_READ && IO_ADDR == 16'h0028 |=> IO_RDATA[7:5] == 3'h0)
        else $error("pointer read has upper bits set");
    a_fpu_cause: assert property (FPU_RESET_OUT |-> $past(IO_WRITE) && $past(IO_ADDR[9:0]) == 10'h0f1)
        else $error("coprocessor reset without a write to its port");
    a_fpu_single: assert property (s_fpu_write ##1 FPU_RESET_OUT |=> !FPU_RESET_OUT)
        else $error("coprocessor reset longer than one cycle");
    a_early_ready: assert property (LOCAL_READY_N == !(MEM_CYCLE && BACKPLANE_MEM_WRITE && CONFIG.post_en
        && !MEM_HOLE_HIT)) else $error("early ready does not follow posting");
    a_alt_port: assert property (ALT_PORT_SELECT == CONFIG.alt_port_en)
        else $error("alternate port select differs from its enable");
    a_parity_block: assert property (CONFIG.parity_override [*4] |-> !PARITY_ERROR_TO_NMI)
        else $error("parity error passed while overridden");
    a_hold_drop: assert property (!HOLD_ACK_CPU |=> !DMA_HOLD_ACK)
        else $error("dma hold grant kept after cpu grant dropped");
    a_hold_direct: assert property (HOLD_ACK_CPU && !CONFIG.drain_handshake |=> DMA_HOLD_ACK)
        else $error("dma hold grant late without drain handshake");
    a_ext_page: assert property (EXT_PAGE_SELECT |-> CONFIG.ext_page_en && IO_ADDR[15:4] == 12'h048)
        else $error("extended page select outside its range");
    a_cycle_range: assert property (CONFIG.backplane_cycles inside {[3'h3:3'h6]})
        else $error("backplane cycle length out of range");
endmodule : iccr_properties
`default_nettype wire

//--- dv/iccr_host.sv
`default_nettype none
module iccr_host (
    input wire logic clk,
    input wire logic [7:0] rdata,
    output logic wr,
    output logic rd,
    output logic [15:0] addr,
    output logic [7:0] wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        wr = 1'b0;
        rd = 1'b0;
        addr = 16'h0000;
        wdata = 8'h00;
    end
    task automatic put(input logic [15:0] a);
        @(posedge clk);
        addr <= a;
    endtask : put
    // Released lines show the inverse, so a stale value can never pass for a fresh one.
    task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask : io_wr
    task automatic io_rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        #1 d = rdata;
    endtask : io_rd
endmodule : iccr_host
`default_nettype wire

//--- dv/iccr_regs_test.sv
`default_nettype none
module iccr_regs_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic io_wr, io_rd, claim, rdy_b, ioh, memh, fpu, ext, alt, nmi, dack;
    logic [15:0] addr;
    logic [7:0] wd, rdata, v;
    logic [7:0] n_fpu = 8'h00;
    logic [27:0] maddr = {6'h01, 8'h05, 14'h0000};
    logic mcyc = 1'b0, bpw = 1'b0, par_b = 1'b1, hack = 1'b0, mrdy_b = 1'b1, strap_b = 1'b1;
    iccr_pkg::iccr_config_type cfg;
    logic [4:0] idx [8] = '{5'h01, 5'h02, 5'h04, 5'h06, 5'h07, 5'h08, 5'h09, 5'h1f};
    logic [7:0] msk [8] = '{8'h0f, 8'h3f, 8'h07, 8'h1f, 8'h0f, 8'h1b, 8'hff, 8'hff};
    logic [3:0] clks [6] = '{4'h1, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};
    int n_mismatch = 0;
    int n_checks = 0;
    int cyc = 0;
    always #25 clk = ~clk;
    iccr_host u_host (.clk(clk), .rdata(rdata), .wr(io_wr), .rd(io_rd), .addr(addr), .wdata(wd));
    iccr_regs u_dut (.CLK_SYS(clk), .RST_B(rst_b), .IO_WRITE(io_wr), .IO_READ(io_rd), .IO_ADDR(addr),
        .IO_WDATA(wd), .IO_RDATA(rdata), .IO_CLAIM(claim), .MEM_ADDR(maddr), .MEM_CYCLE(mcyc),
        .BACKPLANE_MEM_WRITE(bpw), .LOCAL_READY_N(rdy_b), .IO_HOLE_HIT(ioh), .MEM_HOLE_HIT(memh),
        .FPU_RESET_OUT(fpu), .EXT_PAGE_SELECT(ext), .ALT_PORT_SELECT(alt), .PARITY_N(par_b),
        .PARITY_ERROR_TO_NMI(nmi), .HOLD_ACK_CPU(hack), .MEM_READY_N(mrdy_b), .DMA_HOLD_ACK(dack),
        .ADDR20_CLAMP_N(strap_b), .CONFIG(cfg));
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk8
    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask : chk1
    task automatic wreg(input logic [4:0] i, input logic [7:0] d);
        u_host.io_wr(16'h0028, {3'h0, i});
        u_host.io_wr(16'h0024, d);
        #1;
    endtask : wreg
    task automatic rreg(input logic [4:0] i, input logic [7:0] exp);
        u_host.io_wr(16'h0028, {3'h0, i});
        u_host.io_rd(16'h0024, v);
        chk8(v, exp);
    endtask : rreg
    task automatic test_done;
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (rst_b) begin
            n_fpu <= n_fpu + {7'h00, fpu};
        end
        if (cyc == 20000) begin
            n_mismatch++;
            test_done();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        u_host.io_rd(16'h0028, v);
        chk8(v, 8'h00);
        wreg(5'h00, 8'hff);
        rreg(5'h00, {iccr_pkg::CHIP_IDENT, iccr_pkg::CHIP_REVISION});
        chk1(cfg.rom_8bit, 1'b1);
        foreach (idx[k]) begin
            rreg(idx[k], 8'h00);
            wreg(idx[k], 8'hff);
            rreg(idx[k], msk[k]);
            wreg(idx[k], 8'h00);
        end
        u_host.io_rd(16'h0428, v);
        chk8(v, 8'h1f);
        wreg(5'h02, 8'h06);
        chk1(alt, 1'b1);
        u_host.io_wr(16'h0428, 8'h01);
        u_host.io_rd(16'h0028, v);
        chk8(v, 8'h02);
        foreach (clks[k]) begin
            wreg(5'h01, {4'h0, clks[k]});
            chk8({4'h0, cfg.clock_select}, {4'h0, clks[k]});
        end
        for (int f = 0; f < 4; f++) begin
            wreg(5'h02, 8'(f << 3));
            wreg(5'h06, 8'(f << 3));
            chk8({5'h00, cfg.backplane_cycles}, 8'(6 - f));
            chk8({6'h00, cfg.dma_wait_select}, 8'(3 - f));
        end
        wreg(5'h07, 8'h00);
        chk8({4'h0, cfg.rom_oe_cycles}, 8'h05);
        wreg(5'h07, 8'h0f);
        chk8({4'h0, cfg.rom_oe_cycles}, 8'h03);
        chk8({5'h00, cfg.video_bios_shared, cfg.rom_128k, cfg.mid_bios_en}, 8'h07);
        wreg(5'h07, 8'h04);
        chk8({5'h00, cfg.video_bios_shared, cfg.rom_128k, cfg.mid_bios_en}, 8'h02);
        wreg(5'h04, 8'h01);
        chk8({6'h00, cfg.fpu_std_present, cfg.fpu_alt_present}, 8'h02);
        wreg(5'h06, 8'h01);
        chk1(cfg.dma_clk_inverted, 1'b1);
        wreg(5'h02, 8'h01);
        @(posedge clk);
        mcyc <= 1'b1;
        bpw <= 1'b1;
        @(posedge clk);
        #1 chk1(rdy_b, 1'b0);
        wreg(5'h16, 8'h05);
        wreg(5'h17, 8'h01);
        wreg(5'h08, 8'h01);
        chk1(memh, 1'b1);
        chk1(rdy_b, 1'b1);
        @(posedge clk);
        maddr <= maddr + 28'h0004000;
        @(posedge clk);
        #1 chk1(memh, 1'b0);
        wreg(5'h10, 8'h32);
        wreg(5'h11, 8'h33);
        wreg(5'h08, 8'h08);
        u_host.put(16'h032f);
        #1 chk1(ioh, 1'b1);
        u_host.put(16'h0330);
        #1 chk1(ioh, 1'b0);
        wreg(5'h06, 8'h02);
        u_host.put(16'h0485);
        #1 chk1(ext, 1'b1);
        wreg(5'h06, 8'h00);
        u_host.put(16'h0485);
        #1 chk1(ext, 1'b0);
        u_host.io_wr(16'h00f1, 8'h5a);
        repeat (2) @(posedge clk);
        #1 chk8(n_fpu, 8'h01);
        wreg(5'h04, 8'h04);
        u_host.io_wr(16'h00f1, 8'ha5);
        repeat (2) @(posedge clk);
        #1 chk8(n_fpu, 8'h01);
        @(posedge clk);
        par_b <= 1'b0;
        repeat (8) @(posedge clk);
        #1 chk1(nmi, 1'b1);
        wreg(5'h02, 8'h20);
        repeat (8) @(posedge clk);
        #1 chk1(nmi, 1'b0);
        @(posedge clk);
        hack <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk1(dack, 1'b1);
        @(posedge clk);
        hack <= 1'b0;
        wreg(5'h06, 8'h04);
        @(posedge clk);
        hack <= 1'b1;
        repeat (8) @(posedge clk);
        #1 chk1(dack, 1'b0);
        @(posedge clk);
        mrdy_b <= 1'b0;
        repeat (8) @(posedge clk);
        #1 chk1(dack, 1'b1);
        @(posedge clk);
        hack <= 1'b0;
        rst_b <= 1'b0;
        strap_b <= 1'b0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk1(cfg.rom_8bit, 1'b0);
        chk1(dack, 1'b0);
        u_host.io_rd(16'h0028, v);
        chk8(v, 8'h00);
        rreg(5'h06, 8'h00);
        test_done();
    end
endmodule : iccr_regs_test
bind iccr_regs iccr_properties u_props (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .IO_WRITE(IO_WRITE),
    .IO_READ(IO_READ), .IO_ADDR(IO_ADDR), .IO_RDATA(IO_RDATA), .IO_CLAIM(IO_CLAIM), .MEM_CYCLE(MEM_CYCLE),
    .BACKPLANE_MEM_WRITE(BACKPLANE_MEM_WRITE), .LOCAL_READY_N(LOCAL_READY_N), .MEM_HOLE_HIT(MEM_HOLE_HIT),
    .FPU_RESET_OUT(FPU_RESET_OUT), .EXT_PAGE_SELECT(EXT_PAGE_SELECT), .ALT_PORT_SELECT(ALT_PORT_SELECT),
    .PARITY_ERROR_TO_NMI(PARITY_ERROR_TO_NMI), .HOLD_ACK_CPU(HOLD_ACK_CPU), .DMA_HOLD_ACK(DMA_HOLD_ACK),
    .CONFIG(CONFIG));
`default_nettype wire
